// file: core/rcp_pkg.sv
// ****************************************************************
// Resampler control page constants
// ****************************************************************
package rcp_pkg;

    // Page and register offsets inside the paged control space.
    localparam logic [7:0] PAGE_ID       = 8'h40;
    localparam logic [4:0] OFS_CHAN_FILT = 5'h10;
    localparam logic [4:0] OFS_MULT      = 5'h11;
    localparam logic [4:0] OFS_FSEL      = 5'h12;
    localparam logic [4:0] OFS_SHIFT     = 5'h13;
    localparam logic [4:0] OFS_ROUTE     = 5'h14;
    localparam logic [4:0] OFS_ADD       = 5'h15;
    localparam logic [4:0] OFS_CLKDIV    = 5'h16;
    localparam logic [4:0] OFS_RATIO     = 5'h17;
    localparam logic [4:0] OFS_LAST      = 5'h1F;

    // Register indices, counted from the first offset of the page.
    localparam logic [2:0] IDX_CHAN_FILT = 3'h0;
    localparam logic [2:0] IDX_MULT      = 3'h1;
    localparam logic [2:0] IDX_FSEL      = 3'h2;
    localparam logic [2:0] IDX_SHIFT     = 3'h3;
    localparam logic [2:0] IDX_ROUTE     = 3'h4;
    localparam logic [2:0] IDX_ADD       = 3'h5;
    localparam logic [2:0] IDX_CLKDIV    = 3'h6;
    localparam logic [2:0] IDX_RATIO     = 3'h7;

    // Values after reset.
    localparam logic [7:0] RST_CHAN_FILT = 8'h23;
    localparam logic [7:0] RST_MULT      = 8'h0E;
    localparam logic [7:0] RST_FSEL      = 8'h00;
    localparam logic [7:0] RST_SHIFT     = 8'h34;
    localparam logic [7:0] RST_ROUTE     = 8'hE4;
    localparam logic [7:0] RST_ADD       = 8'h70;
    localparam logic [7:0] RST_CLKDIV    = 8'h00;
    localparam logic [7:0] RST_RATIO     = 8'h00;

    // Writable bits; unused bits read as zero.
    localparam logic [7:0] MSK_SEVEN     = 8'h7F;
    localparam logic [7:0] MSK_FULL      = 8'hFF;

    // Field positions.
    localparam int unsigned POS_CHAN_CNT = 0;
    localparam int unsigned POS_FILT_CNT = 2;
    localparam int unsigned POS_RESAMPLER_ALIGN_SOURCE = 4;
    localparam int unsigned POS_MULT_CNT = 0;
    localparam int unsigned POS_ASYM     = 6;
    localparam int unsigned POS_SHIFT    = 0;
    localparam int unsigned POS_ROUND    = 4;
    localparam int unsigned POS_TAG22    = 6;
    localparam int unsigned POS_RAT_SYNC = 4;

    // Rounding codes and low-bit counts left unrounded.
    localparam logic [1:0] RND_12        = 2'h0;
    localparam logic [1:0] RND_16        = 2'h1;
    localparam logic [1:0] RND_20        = 2'h2;
    localparam logic [4:0] DROP_12       = 5'h0C;
    localparam logic [4:0] DROP_16       = 5'h08;
    localparam logic [4:0] DROP_20       = 5'h04;
    localparam logic [4:0] DROP_22       = 5'h02;
    localparam logic [4:0] DROP_24       = 5'h00;

    // Output word limits.
    localparam logic [23:0] WORD_MAX     = 24'h7F_FFFF;
    localparam logic [23:0] WORD_MIN     = 24'h80_0000;

endpackage : rcp_pkg

// file: core/rcp_pair_buffer.sv
`timescale 1ns/1ps
// ****************************************************************
// Small flip-flop FIFO with valid and ready on both sides
// ****************************************************************
module rcp_pair_buffer #(
    parameter int unsigned WIDTH = 24,
    parameter int unsigned DEPTH = 2
) (
    input  wire logic             clock_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    input  wire logic             wr_valid_i,
    output logic                  wr_ready_o,
    input  wire logic [WIDTH-1:0] wr_data_i,
    output logic                  rd_valid_o,
    input  wire logic             rd_ready_i,
    output logic      [WIDTH-1:0] rd_data_o
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Only power-of-two depths wrap the pointers correctly.
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
        $error("rcp_pair_buffer: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wptr_reg;
    logic [AW-1:0]    rptr_reg;
    logic [AW:0]      count_reg;
    wire              push = ce_i & wr_valid_i & wr_ready_o;
    wire              pop  = ce_i & rd_valid_o & rd_ready_i;

    // Full and empty come straight from the fill count.
    assign wr_ready_o = (count_reg != (AW + 1)'(DEPTH));
    assign rd_valid_o = (count_reg != '0);
    assign rd_data_o  = mem_reg[rptr_reg];

    // Pointers and count move only on accepted transfers.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wptr_reg  <= '0;
            rptr_reg  <= '0;
            count_reg <= '0;
        end else begin
            if (push) wptr_reg <= wptr_reg + 1'b1;
            if (pop) rptr_reg <= rptr_reg + 1'b1;
            if (push && !pop) count_reg <= count_reg + 1'b1;
            else if (pop && !push) count_reg <= count_reg - 1'b1;
        end
    end

    // Storage is written at the write pointer.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < int'(DEPTH); i++) mem_reg[i] <= '0;
        end else if (push) begin
            mem_reg[wptr_reg] <= wr_data_i;
        end
    end

endmodule : rcp_pair_buffer

// file: core/rcp_core.sv
`timescale 1ns/1ps
// ****************************************************************
// Resampler control page and output word path
// ****************************************************************
module rcp_core #(
    parameter int unsigned IN_W = 24
) (
    input  wire logic            clock_i,
    input  wire logic            rst_i,
    input  wire logic            ce_i,
    input  wire logic [7:0]      reg_page_i,
    input  wire logic [4:0]      reg_addr_i,
    input  wire logic            reg_wr_i,
    input  wire logic            reg_rd_i,
    input  wire logic [7:0]      reg_wdata_i,
    output logic      [7:0]      reg_rdata_o,
    input  wire logic [7:0]      sync_i,
    input  wire logic            in_valid_i,
    output logic                 in_ready_o,
    input  wire logic [1:0]      in_chan_i,
    input  wire logic [IN_W-1:0] in_data_i,
    input  wire logic [7:0]      tag_lsbs_i,
    output logic                 out_valid_o,
    input  wire logic            out_ready_i,
    output logic      [23:0]     out_data_o,
    output logic      [1:0]      out_chan_o,
    output logic      [1:0]      out_filter_o,
    output logic      [1:0]      out_ratio_o,
    output logic      [7:0]      out_phase_o,
    output logic      [2:0]      coef_stride_o,
    output logic                 asym_taps_o,
    output logic                 res_tick_o
);
    localparam int unsigned BUF_W = 24 + 2 + 2 + 2 + 8;

    // The output word is 24 bits; wider input would be lost.
    if (IN_W < 8 || IN_W > 24) begin : g_chk
        $error("rcp_core: IN_W must lie in 8..24");
    end

    // ************************************************************
    // Decoding helpers
    // ************************************************************

    // Turns a count code into the mask of legal index bits.
    function automatic logic [1:0] code_mask(input logic [1:0] code);
        code_mask = (code == 2'h0) ? 2'h0 : (code == 2'h1) ? 2'h1 : 2'h3;
    endfunction : code_mask

    // Picks the two-bit field of a packed byte by index.
    function automatic logic [1:0] pick2(input logic [7:0] v,
                                         input logic [1:0] i);
        pick2 = v[{i, 1'b0} +: 2];
    endfunction : pick2

    // Number of low bits left unrounded for a code and tag mode.
    function automatic logic [4:0] drop_bits(input logic [1:0] code,
                                             input logic       tag);
        unique case (code)
            rcp_pkg::RND_12: drop_bits = rcp_pkg::DROP_12;
            rcp_pkg::RND_16: drop_bits = rcp_pkg::DROP_16;
            rcp_pkg::RND_20: drop_bits = rcp_pkg::DROP_20;
            default: drop_bits = tag ? rcp_pkg::DROP_22 : rcp_pkg::DROP_24;
        endcase
    endfunction : drop_bits

    // ************************************************************
    // Register file
    // ************************************************************
    logic [7:0] cfg_reg [8];
    logic [7:0] reg_rdata_reg;

    // Only page 64, offsets 16..23, hit a register.
    wire       page_hit = (reg_page_i == rcp_pkg::PAGE_ID);
    wire       in_range = (reg_addr_i >= rcp_pkg::OFS_CHAN_FILT) &&
                          (reg_addr_i <= rcp_pkg::OFS_RATIO);
    wire       reg_hit  = page_hit & in_range;
    wire [2:0] reg_idx  = reg_addr_i[2:0];
    wire       wr_hit   = ce_i & reg_wr_i & reg_hit;

    // Writable-bit mask of each register.
    wire [7:0] wr_mask =
        (reg_idx == rcp_pkg::IDX_FSEL   || reg_idx == rcp_pkg::IDX_ROUTE ||
         reg_idx == rcp_pkg::IDX_CLKDIV || reg_idx == rcp_pkg::IDX_RATIO)
        ? rcp_pkg::MSK_FULL : rcp_pkg::MSK_SEVEN;

    // Register fields as used by the datapath.
    wire [1:0] chan_code  = cfg_reg[rcp_pkg::IDX_CHAN_FILT]
                                   [rcp_pkg::POS_CHAN_CNT +: 2];
    wire [1:0] filt_code  = cfg_reg[rcp_pkg::IDX_CHAN_FILT]
                                   [rcp_pkg::POS_FILT_CNT +: 2];
    wire [2:0] res_src    = cfg_reg[rcp_pkg::IDX_CHAN_FILT]
                                   [rcp_pkg::POS_RESAMPLER_ALIGN_SOURCE +: 3];
    wire [5:0] mult_code  = cfg_reg[rcp_pkg::IDX_MULT]
                                   [rcp_pkg::POS_MULT_CNT +: 6];
    wire [3:0] gain_shift = cfg_reg[rcp_pkg::IDX_SHIFT]
                                   [rcp_pkg::POS_SHIFT +: 4];
    wire [1:0] round_code = cfg_reg[rcp_pkg::IDX_SHIFT]
                                   [rcp_pkg::POS_ROUND +: 2];
    wire       tag_mode   = cfg_reg[rcp_pkg::IDX_SHIFT][rcp_pkg::POS_TAG22];
    wire [3:0] add_bits   = cfg_reg[rcp_pkg::IDX_ADD][3:0];
    wire [2:0] rat_src    = cfg_reg[rcp_pkg::IDX_ADD]
                                   [rcp_pkg::POS_RAT_SYNC +: 3];
    wire [7:0] divisor    = cfg_reg[rcp_pkg::IDX_CLKDIV];

    // Writes store only the defined bits of the addressed register.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_reg[rcp_pkg::IDX_CHAN_FILT] <= rcp_pkg::RST_CHAN_FILT;
            cfg_reg[rcp_pkg::IDX_MULT]      <= rcp_pkg::RST_MULT;
            cfg_reg[rcp_pkg::IDX_FSEL]      <= rcp_pkg::RST_FSEL;
            cfg_reg[rcp_pkg::IDX_SHIFT]     <= rcp_pkg::RST_SHIFT;
            cfg_reg[rcp_pkg::IDX_ROUTE]     <= rcp_pkg::RST_ROUTE;
            cfg_reg[rcp_pkg::IDX_ADD]       <= rcp_pkg::RST_ADD;
            cfg_reg[rcp_pkg::IDX_CLKDIV]    <= rcp_pkg::RST_CLKDIV;
            cfg_reg[rcp_pkg::IDX_RATIO]     <= rcp_pkg::RST_RATIO;
        end else if (wr_hit) begin
            cfg_reg[reg_idx] <= reg_wdata_i & wr_mask;
        end
    end

    // Reads are registered; offsets 24..31 and other pages read zero.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) reg_rdata_reg <= '0;
        else if (ce_i && reg_rd_i)
            reg_rdata_reg <= reg_hit ? cfg_reg[reg_idx] : 8'h00;
    end
    assign reg_rdata_o = reg_rdata_reg;

    // ************************************************************
    // Sync inputs: three flops, a change counts once two agree
    // ************************************************************
    logic [7:0] sync_s1_reg;
    logic [7:0] sync_s2_reg;
    logic [7:0] sync_s3_reg;
    logic [7:0] sync_lvl_reg;
    wire  [7:0] sync_lvl_next = (sync_s2_reg & sync_s3_reg) |
                                (sync_lvl_reg & (sync_s2_reg | sync_s3_reg));
    wire  [7:0] sync_rise     = sync_lvl_next & ~sync_lvl_reg;
    wire        resampler_align_source      = ce_i & sync_rise[res_src];
    wire        rat_sync      = ce_i & sync_rise[rat_src];

    // Synchroniser chain and filtered level of each sync pin.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sync_s1_reg  <= '0;
            sync_s2_reg  <= '0;
            sync_s3_reg  <= '0;
            sync_lvl_reg <= '0;
        end else if (ce_i) begin
            sync_s1_reg  <= sync_i;
            sync_s2_reg  <= sync_s1_reg;
            sync_s3_reg  <= sync_s2_reg;
            sync_lvl_reg <= sync_lvl_next;
        end
    end

    // Working rate map follows the written one only on its sync.
    logic [7:0] ratio_act_reg;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) ratio_act_reg <= rcp_pkg::RST_RATIO;
        else if (rat_sync)
            ratio_act_reg <= cfg_reg[rcp_pkg::IDX_RATIO];
    end

    // ************************************************************
    // Resampler rate enable
    // ************************************************************
    logic [8:0] div_acc_reg;
    wire  [8:0] div_den   = {1'b0, divisor} + 9'h001;
    wire        div_full  = (divisor <= 8'h01); // rate at or above clock
    wire  [8:0] div_sum   = div_acc_reg + 9'h002;
    wire        div_fire  = div_full | (div_sum >= div_den);
    wire        tick      = ce_i & div_fire;

    // Adds two per clock and fires each time one plus divisor is reached.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) div_acc_reg <= '0;
        else if (ce_i) begin
            if (div_full) div_acc_reg <= '0;
            else if (div_fire) div_acc_reg <= div_sum - div_den;
            else div_acc_reg <= div_sum;
        end
    end
    assign res_tick_o = tick;

    // ************************************************************
    // Input, adjacent sums and routing
    // ************************************************************
    logic [IN_W-1:0] held_reg;
    logic            held_vld_reg;
    logic [IN_W:0]   acc_reg;
    logic [1:0]      dst_reg;
    logic            busy_reg;
    logic [5:0]      mcnt_reg;
    logic [7:0]      phase_reg [4];
    wire             buf_ready;

    assign in_ready_o = tick & ~busy_reg;
    wire        accept  = in_valid_i & in_ready_o;
    wire        hold    = accept & add_bits[in_chan_i];
    wire        start   = accept & ~add_bits[in_chan_i];
    wire [IN_W:0] in_ext   = {in_data_i[IN_W-1], in_data_i};
    wire [IN_W:0] held_ext = held_vld_reg ? {held_reg[IN_W-1], held_reg}
                                          : '0;
    wire [IN_W:0] in_sum   = in_ext + held_ext;
    wire [1:0]    in_dst   = pick2(cfg_reg[rcp_pkg::IDX_ROUTE], in_chan_i)
                             & code_mask(chan_code);
    wire          done     = busy_reg & tick & (mcnt_reg == 6'h00);
    wire          push     = done & buf_ready;

    // Held partial sum waits for the next presented sample.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            held_reg     <= '0;
            held_vld_reg <= 1'b0;
        end else if (hold) begin
            held_reg     <= in_sum[IN_W-1:0];
            held_vld_reg <= 1'b1;
        end else if (start) begin
            held_vld_reg <= 1'b0;
        end
    end

    // One output takes one plus multiply count resampler ticks.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            acc_reg  <= '0;
            dst_reg  <= '0;
            busy_reg <= 1'b0;
            mcnt_reg <= '0;
        end else if (start) begin
            acc_reg  <= in_sum;
            dst_reg  <= in_dst;
            busy_reg <= 1'b1;
            mcnt_reg <= mult_code;
        end else if (busy_reg && tick && mcnt_reg != 6'h00) begin
            mcnt_reg <= mcnt_reg - 6'h01;
        end else if (push) begin
            busy_reg <= 1'b0;
        end
    end

    // Delay accumulators count words; the resampler sync clears all.
    for (genvar g = 0; g < 4; g++) begin : g_phase
        always_ff @(posedge clock_i or posedge rst_i) begin
            if (rst_i) phase_reg[g] <= '0;
            else if (resampler_align_source) phase_reg[g] <= '0;
            else if (push && dst_reg == 2'(g))
                phase_reg[g] <= phase_reg[g] + 8'h01;
        end
    end

    // ************************************************************
    // Gain shift, rounding and tag insertion
    // ************************************************************
    wire signed [39:0] wide   = 40'(signed'(acc_reg)) <<< gain_shift;
    wire               in_rng = (wide[39:23] == {17{wide[23]}});
    wire [23:0]        sat    = in_rng ? wide[23:0]
                              : (wide[39] ? rcp_pkg::WORD_MIN
                                          : rcp_pkg::WORD_MAX);
    wire [4:0]         drop   = drop_bits(round_code, tag_mode);
    wire [24:0]        half   = (drop == 5'h00) ? 25'h000_0000
                              : (25'h000_0001 << (drop - 5'h01));
    wire [24:0]        rsum   = {sat[23], sat} + half;
    wire [23:0]        rnd    = (rsum[24] != rsum[23]) ? rcp_pkg::WORD_MAX
                                                      : rsum[23:0];
    wire [23:0]        lo_msk = (24'h00_0001 << drop) - 24'h00_0001;
    wire [23:0]        kept   = (rnd & ~lo_msk) | (sat & lo_msk);
    wire [1:0]         tag2   = pick2(tag_lsbs_i, dst_reg);
    wire [23:0]        word   = tag_mode ? {kept[23:2], tag2}
                                         : kept;
    wire [1:0]         filt   = pick2(cfg_reg[rcp_pkg::IDX_FSEL], dst_reg)
                                & code_mask(filt_code);
    wire [1:0]         ratio  = pick2(ratio_act_reg, dst_reg);
    wire [BUF_W-1:0]   buf_in = {word, dst_reg, filt, ratio,
                                 phase_reg[dst_reg]};
    wire [BUF_W-1:0]   buf_out;

    // Coefficient layout: stride is filter total, filter index is offset.
    assign coef_stride_o = {1'b0, code_mask(filt_code)} + 3'h1;
    assign asym_taps_o   =
        cfg_reg[rcp_pkg::IDX_MULT][rcp_pkg::POS_ASYM];

    // ************************************************************
    // Output buffer
    // ************************************************************

    // Two entries absorb a stall by the receiver without losing words.
    rcp_pair_buffer #(
        .WIDTH (BUF_W),
        .DEPTH (2)
    ) u_buffer (
        .clock_i    (clock_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .wr_valid_i (done),
        .wr_ready_o (buf_ready),
        .wr_data_i  (buf_in),
        .rd_valid_o (out_valid_o),
        .rd_ready_i (out_ready_i),
        .rd_data_o  (buf_out)
    );

    // Buffer fields back onto the output ports.
    assign out_data_o   = buf_out[BUF_W-1 -: 24];
    assign out_chan_o   = buf_out[13:12];
    assign out_filter_o = buf_out[11:10];
    assign out_ratio_o  = buf_out[9:8];
    assign out_phase_o  = buf_out[7:0];

endmodule : rcp_core

// file: dv/rcp_core_assertions.sv
`timescale 1ns/1ps
// ************************************************************
// Port checker for the resampler control page
// ************************************************************
module rcp_core_checker (
    input wire logic        clock_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic [7:0]  reg_page_i,
    input wire logic [4:0]  reg_addr_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic        in_valid_i,
    input wire logic        in_ready_o,
    input wire logic        out_valid_o,
    input wire logic        out_ready_i,
    input wire logic [23:0] out_data_o,
    input wire logic [2:0]  coef_stride_o,
    input wire logic        asym_taps_o,
    input wire logic        res_tick_o
);
    // Page hit qualifiers shared by the properties.
    wire logic on_pg = ce_i && reg_page_i == 8'h40;
    wire logic rd_pg = on_pg && reg_rd_i;
    wire logic wr_pg = on_pg && reg_wr_i;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    chk_off_page: assert property (
        ce_i && reg_rd_i && !on_pg |=> reg_rdata_o == 8'h00)
        else $error("Off page read gave data.");
    chk_unused_read: assert property (
        rd_pg && reg_addr_i > 5'h17 |=> reg_rdata_o == 8'h00)
        else $error("Unused address gave data.");
    chk_select_readback: assert property (
        wr_pg && reg_addr_i == 5'h12 ##1 !reg_wr_i ##1
        rd_pg && reg_addr_i == 5'h12 |=> reg_rdata_o == $past(reg_wdata_i, 3))
        else $error("Filter select read back wrong.");
    chk_seven_bit: assert property (
        rd_pg && reg_addr_i inside {5'h10, 5'h11, 5'h13, 5'h15}
        |=> !reg_rdata_o[7]) else $error("Unused bit read as one.");
    chk_asym_bit: assert property (
        wr_pg && reg_addr_i == 5'h11 |=> asym_taps_o == $past(reg_wdata_i[6]))
        else $error("Asymmetric flag wrong.");
    chk_stride_code: assert property (
        wr_pg && reg_addr_i == 5'h10 && reg_wdata_i[3] == reg_wdata_i[2]
        |=> coef_stride_o == ($past(reg_wdata_i[3]) ? 3'h4 : 3'h1))
        else $error("Coefficient stride wrong.");
    chk_word_holds: assert property (
        out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
        else $error("Output word dropped.");
    chk_ready_tick: assert property (
        in_ready_o |-> res_tick_o && ce_i) else $error("Ready off tick.");
    cov_word: cover property (out_valid_o && out_ready_i);
    cov_take: cover property (in_valid_i && in_ready_o);
    cov_read: cover property (rd_pg);
endmodule : rcp_core_checker
bind rcp_core rcp_core_checker u_rcp_core_checker (.*);

// file: dv/rcp_ddc_source.sv
`timescale 1ns/1ps
// ************************************************************
// Down converter channel model feeding the sample stream
// ************************************************************
module rcp_ddc_source (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        go_i,
    input  wire logic [1:0]  chan_i,
    input  wire logic [23:0] data_i,
    input  wire logic        ready_i,
    output logic             valid_o,
    output logic      [1:0]  chan_o,
    output logic      [23:0] data_o
);
    // Holds a sample until taken, then scrambles the released lines.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            valid_o <= 1'b0;
            chan_o  <= 2'h0;
            data_o  <= 24'h00_0000;
        end else if (valid_o && ready_i) begin
            valid_o <= 1'b0;
            chan_o  <= ~chan_o;
            data_o  <= ~data_o;
        end else if (go_i && !valid_o) begin
            valid_o <= 1'b1;
            chan_o  <= chan_i;
            data_o  <= data_i;
        end
    end
endmodule : rcp_ddc_source

// file: dv/rcp_core_tb.sv
`timescale 1ns/1ps
// ************************************************************
// Self-checking bench for the resampler control page
// ************************************************************
module rcp_core_tb;
    localparam logic [7:0] RV [8] = '{8'h23, 8'h0E, 8'h00, 8'h34,
                                      8'hE4, 8'h70, 8'h00, 8'h00};
    logic        clock_i, rst_i, wr, rd, go, rdy, sv, sr, ov, tick;
    logic [7:0]  pg, wdata, rdata, sync, tag, ph;
    logic [4:0]  addr;
    logic [1:0]  chan, sc, oc, ra, orat, of, fl;
    logic [23:0] data, sd, od;
    logic [7:0]  oph;
    logic [2:0]  cs;
    int          n_fail = 0, samples_checked = 0, cyc = 0, k;
    rcp_core u_rcp_core (.clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1),
        .reg_page_i(pg), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .sync_i(sync),
        .in_valid_i(sv), .in_ready_o(sr), .in_chan_i(sc), .in_data_i(sd),
        .tag_lsbs_i(tag), .out_valid_o(ov), .out_ready_i(rdy),
        .out_data_o(od), .out_chan_o(oc), .out_filter_o(of),
        .out_ratio_o(orat), .out_phase_o(oph), .coef_stride_o(cs),
        .asym_taps_o(), .res_tick_o(tick));
    rcp_ddc_source u_rcp_ddc_source (.clock_i(clock_i), .rst_i(rst_i),
        .go_i(go), .chan_i(chan), .data_i(data), .ready_i(sr),
        .valid_o(sv), .chan_o(sc), .data_o(sd));
    // Clock and hang guard.
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task tally_and_finish();
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    task chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask : chk
    task wr_reg(input logic [4:0] a, input logic [7:0] d);
        @(posedge clock_i) {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clock_i) wr <= 1'b0;
    endtask : wr_reg
    task rd_reg(input logic [4:0] a, input logic [7:0] e);
        @(posedge clock_i) {addr, rd} <= {a, 1'b1};
        @(posedge clock_i) rd <= 1'b0;
        #1 chk({16'h0000, rdata}, {16'h0000, e});
    endtask : rd_reg
    task send(input logic [1:0] c, input logic [23:0] d);
        @(posedge clock_i) {chan, data, go} <= {c, d, 1'b1};
        do @(posedge clock_i); while (sv);
        go <= 1'b0;
    endtask : send
    task get(input logic [23:0] d, input logic [1:0] c);
        int n;
        n = 0;
        do begin
            @(posedge clock_i);
            #1 n++;
        end while (ov !== 1'b1 && n < 300);
        chk(od, d);
        chk({22'h00_0000, oc}, {22'h00_0000, c});
        {ph, ra, fl} = {oph, orat, of};
        @(posedge clock_i) rdy <= 1'b1;
        @(posedge clock_i) rdy <= 1'b0;
    endtask : get
    task pulse(input int n);
        @(posedge clock_i) sync <= 8'h01 << n;
        repeat (6) @(posedge clock_i);
        sync <= 8'h00;
        repeat (6) @(posedge clock_i);
    endtask : pulse
    task ticks(input int e);
        int c;
        c = 0;
        repeat (20) @(posedge clock_i) #1 c += int'(tick);
        chk(24'(c), 24'(e));
    endtask : ticks
    // Main sequence of tests.
    initial begin
        {rst_i, wr, rd, go, rdy} = 5'h10;
        {pg, addr, wdata, sync, tag, chan, data} = {8'h40, 21'h0, 8'h02, 26'h0};
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0;
        for (k = 0; k < 8; k++) rd_reg(5'h10 + 5'(k), RV[k]);
        rd_reg(5'h18, 8'h00);
        ticks(20);
        for (k = 0; k < 8; k++) wr_reg(5'h10 + 5'(k), 8'hF7);
        for (k = 0; k < 8; k++) rd_reg(5'h10 + 5'(k),
            (k == 0 || k == 1 || k == 3 || k == 5) ? 8'h77 : 8'hF7);
        pg <= 8'h41;
        wr_reg(5'h12, 8'h5A);
        rd_reg(5'h12, 8'h00);
        pg <= 8'h40;
        rd_reg(5'h12, 8'hF7);
        wr_reg(5'h10, 8'h2F);
        #1 chk(24'(cs), 24'h00_0004);
        for (k = 0; k < 8; k++) wr_reg(5'h10 + 5'(k), RV[k]);
        $display("test registers done");
        send(2'h0, 24'h00_0001);
        get(24'h00_0010, 2'h0);
        wr_reg(5'h14, 8'h1B);
        wr_reg(5'h12, 8'hC0);
        rd_reg(5'h12, 8'hC0);
        send(2'h0, 24'h00_0002);
        get(24'h00_0020, 2'h3);
        chk({22'h00_0000, fl}, 24'h00_0000);
        wr_reg(5'h14, 8'hE4);
        wr_reg(5'h15, 8'h71);
        send(2'h0, 24'h00_0005);
        send(2'h1, 24'h00_0003);
        get(24'h00_0080, 2'h1);
        wr_reg(5'h15, 8'h70);
        wr_reg(5'h13, 8'h70);
        send(2'h0, 24'h00_0101);
        get(24'h00_0102, 2'h0);
        for (k = 0; k < 4; k++) begin
            wr_reg(5'h13, 8'(k << 4));
            send(2'h0, 24'h00_0800 >> (4 * (k % 3)));
            get((k == 3) ? 24'h00_0800 : 24'h00_1800 >> (4 * k), 2'h0);
        end
        wr_reg(5'h13, 8'h34);
        $display("test datapath done");
        pulse(2);
        for (k = 0; k < 2; k++) begin
            send(2'h0, 24'h00_0001);
            get(24'h00_0010, 2'h0);
            chk({16'h0000, ph}, 24'(k));
        end
        wr_reg(5'h17, 8'h03);
        send(2'h0, 24'h00_0001);
        get(24'h00_0010, 2'h0);
        chk({22'h00_0000, ra}, 24'h00_0000);
        pulse(7);
        send(2'h0, 24'h00_0001);
        get(24'h00_0010, 2'h0);
        chk({22'h00_0000, ra}, 24'h00_0003);
        for (k = 0; k < 4; k++) send(2'(k), 24'(k + 1));
        repeat (40) @(posedge clock_i);
        #1 chk({23'h00_0000, sv}, 24'h00_0001);
        for (k = 0; k < 4; k++) get(24'((k + 1) << 4), 2'(k));
        wr_reg(5'h16, 8'h03);
        ticks(10);
        $display("test sync and buffer done");
        tally_and_finish();
    end
endmodule : rcp_core_tb
